/* File: logic/timer_capture_compare.sv */
// 16-bit capture/compare timer with capture-restart, compare, gated and capture/compare modes.
// Assumes an APB master on clk_sys and a timer input already synchronous to clk_sys.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module timer_capture_compare #(
  parameter int PRESCALE_W = timer_cc_pkg::PRESCALE_CNT_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_cc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_out_en,
  output logic timer_irq
);
  logic [15:0] count;
  logic [15:0] reload;
  logic [7:0] reload_hold;
  logic [15:0] capture;
  logic mode_select_top;
  logic [1:0] interrupt_source_select;
  logic [2:0] deadband;
  logic capture_cause_flag;
  logic enable;
  logic input_polarity;
  logic [2:0] prescale;
  logic [2:0] mode_select_low;
  logic out_enable;
  logic [PRESCALE_W-1:0] pres_cnt;
  logic [PRESCALE_W-1:0] pres_limit;
  logic in_prev;
  timer_cc_pkg::arm_type arm;
  logic [3:0] idx;
  logic mapped;
  logic wr_en;
  logic [31:0] rd_word;
  logic [3:0] mode;
  logic is_cr;
  logic is_cmp;
  logic is_gated;
  logic is_cc;
  logic tick;
  logic rise;
  logic fall;
  logic qual_edge;
  logic in_active;
  logic deassert;
  logic cap_evt;
  logic count_step;
  logic match;
  logic reload_evt;
  logic cmp_evt;
  logic deassert_evt;
  logic input_evt;
  logic rc_evt;
  logic next_irq;
  logic sw_count_wr;

  // APB decode; unmapped or misaligned words answer with pslverr
  assign idx = paddr[5:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[timer_cc_pkg::ADDR_W-1:6] == '0) && (idx <= timer_cc_pkg::IDX_LAST);
  assign wr_en = psel && penable && pwrite && mapped;
  assign pready = psel && penable;
  assign sw_count_wr = wr_en && (idx == timer_cc_pkg::IDX_COUNT_HIGH || idx == timer_cc_pkg::IDX_COUNT_LOW);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (idx)
      timer_cc_pkg::IDX_COUNT_HIGH: rd_word[7:0] = count[15:8];
      timer_cc_pkg::IDX_COUNT_LOW: rd_word[7:0] = count[7:0];
      timer_cc_pkg::IDX_RELOAD_HIGH: rd_word[7:0] = reload[15:8];
      timer_cc_pkg::IDX_RELOAD_LOW: rd_word[7:0] = reload[7:0];
      timer_cc_pkg::IDX_CAPTURE_HIGH: rd_word[7:0] = capture[15:8];
      timer_cc_pkg::IDX_CAPTURE_LOW: rd_word[7:0] = capture[7:0];
      timer_cc_pkg::IDX_CONTROL_REG_ZERO: begin
        rd_word[timer_cc_pkg::CTL0_MODE_TOP_BIT] = mode_select_top;
        rd_word[timer_cc_pkg::CTL0_ISEL_LSB +: 2] = interrupt_source_select;
        rd_word[timer_cc_pkg::CTL0_DEADBAND_LSB +: 3] = deadband;
        rd_word[timer_cc_pkg::CTL0_FLAG_BIT] = capture_cause_flag;
      end
      timer_cc_pkg::IDX_CONTROL_REG_ONE: begin
        rd_word[timer_cc_pkg::CTL1_ENABLE_BIT] = enable;
        rd_word[timer_cc_pkg::CTL1_POLARITY_BIT] = input_polarity;
        rd_word[timer_cc_pkg::CTL1_PRESCALE_LSB +: 3] = prescale;
        rd_word[timer_cc_pkg::CTL1_MODE_LSB +: 3] = mode_select_low;
      end
      timer_cc_pkg::IDX_OUTPUT_CONTROL: rd_word[timer_cc_pkg::OUT_ENABLE_BIT] = out_enable;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data and error latched in the setup phase so they come from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= (mapped && !pwrite) ? rd_word : 32'h0000_0000;
      pslverr <= !mapped;
    end
  end

  // Control registers; reserved bit and deadband have no effect here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_select_top <= 1'b0;
      interrupt_source_select <= 2'h0;
      deadband <= 3'h0;
      enable <= 1'b0;
      input_polarity <= 1'b0;
      prescale <= 3'h0;
      mode_select_low <= 3'h0;
      out_enable <= 1'b0;
    end else if (wr_en) begin
      case (idx)
        timer_cc_pkg::IDX_CONTROL_REG_ZERO: begin
          mode_select_top <= pwdata[timer_cc_pkg::CTL0_MODE_TOP_BIT];
          interrupt_source_select <= pwdata[timer_cc_pkg::CTL0_ISEL_LSB +: 2];
          deadband <= pwdata[timer_cc_pkg::CTL0_DEADBAND_LSB +: 3];
        end
        timer_cc_pkg::IDX_CONTROL_REG_ONE: begin
          enable <= pwdata[timer_cc_pkg::CTL1_ENABLE_BIT];
          input_polarity <= pwdata[timer_cc_pkg::CTL1_POLARITY_BIT];
          prescale <= pwdata[timer_cc_pkg::CTL1_PRESCALE_LSB +: 3];
          mode_select_low <= pwdata[timer_cc_pkg::CTL1_MODE_LSB +: 3];
        end
        timer_cc_pkg::IDX_OUTPUT_CONTROL: out_enable <= pwdata[timer_cc_pkg::OUT_ENABLE_BIT];
        default: begin
        end
      endcase
    end
  end
  assign timer_out_en = out_enable;

  // Reload value: high byte waits in a holding byte for the low-byte write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reload <= timer_cc_pkg::RELOAD_RESET;
      reload_hold <= timer_cc_pkg::RELOAD_RESET[15:8];
    end else if (wr_en && idx == timer_cc_pkg::IDX_RELOAD_HIGH) begin
      reload_hold <= pwdata[7:0];
    end else if (wr_en && idx == timer_cc_pkg::IDX_RELOAD_LOW) begin
      reload <= {reload_hold, pwdata[7:0]};
    end
  end

  // Mode decode
  assign mode = {mode_select_top, mode_select_low};
  assign is_cr = enable && (mode == timer_cc_pkg::MODE_CAPTURE_RESTART);
  assign is_cmp = enable && (mode == timer_cc_pkg::MODE_COMPARE);
  assign is_gated = enable && (mode == timer_cc_pkg::MODE_GATED);
  assign is_cc = enable && (mode == timer_cc_pkg::MODE_CAPTURE_COMPARE);

  // Prescaler: factor is two to the power of prescale
  assign pres_limit = PRESCALE_W'((1 << prescale) - 1);
  assign tick = enable && (pres_cnt == pres_limit);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pres_cnt <= '0;
    end else if (!enable || tick) begin
      pres_cnt <= '0;
    end else begin
      pres_cnt <= pres_cnt + PRESCALE_W'(1);
    end
  end

  // Input edge detection; the pin only qualifies events, it never clocks the count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_prev <= 1'b0;
    end else begin
      in_prev <= timer_in;
    end
  end
  assign rise = timer_in && !in_prev;
  assign fall = !timer_in && in_prev;
  assign qual_edge = input_polarity ? fall : rise;
  assign in_active = timer_in ^ input_polarity;
  assign deassert = (in_prev ^ input_polarity) && !in_active;

  // First edge in capture/compare mode only arms the counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arm <= timer_cc_pkg::ARM_WAIT;
    end else begin
      case (arm)
        timer_cc_pkg::ARM_WAIT: if (is_cc && qual_edge) arm <= timer_cc_pkg::ARM_RUN;
        timer_cc_pkg::ARM_RUN: if (!is_cc) arm <= timer_cc_pkg::ARM_WAIT;
        default: arm <= timer_cc_pkg::ARM_WAIT;
      endcase
    end
  end

  // Events
  assign cap_evt = qual_edge && (is_cr || (is_cc && arm == timer_cc_pkg::ARM_RUN));
  assign count_step = tick && (is_cr || is_cmp || (is_gated && in_active) ||
                               (is_cc && arm == timer_cc_pkg::ARM_RUN));
  assign match = count_step && (count == reload);
  assign reload_evt = match && !is_cmp && !cap_evt;
  assign cmp_evt = match && is_cmp;
  assign deassert_evt = is_gated && deassert;
  assign input_evt = cap_evt || deassert_evt;
  assign rc_evt = reload_evt || cmp_evt;

  // Interrupt filter; with the default select codes both classes merge into one request per cycle
  always_comb begin
    case (interrupt_source_select)
      timer_cc_pkg::ISEL_INPUT_ONLY: next_irq = input_evt;
      timer_cc_pkg::ISEL_RELOAD_ONLY: next_irq = rc_evt;
      default: next_irq = input_evt || rc_evt;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= next_irq;
    end
  end

  // Counter; a software byte write wins over hardware in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= timer_cc_pkg::COUNT_RESET;
    end else if (wr_en && idx == timer_cc_pkg::IDX_COUNT_HIGH) begin
      count[15:8] <= pwdata[7:0];
    end else if (wr_en && idx == timer_cc_pkg::IDX_COUNT_LOW) begin
      count[7:0] <= pwdata[7:0];
    end else if (cap_evt || reload_evt) begin
      count <= timer_cc_pkg::COUNT_RESTART;
    end else if (count_step) begin
      count <= count + 16'h0001;
    end
  end

  // Capture register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      capture <= timer_cc_pkg::CAPTURE_RESET;
    end else if (cap_evt) begin
      capture <= count;
    end else if (wr_en && idx == timer_cc_pkg::IDX_CAPTURE_HIGH) begin
      capture[15:8] <= pwdata[7:0];
    end else if (wr_en && idx == timer_cc_pkg::IDX_CAPTURE_LOW) begin
      capture[7:0] <= pwdata[7:0];
    end
  end

  // Cause flag; gated reloads leave it alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      capture_cause_flag <= 1'b0;
    end else if (cap_evt) begin
      capture_cause_flag <= 1'b1;
    end else if (reload_evt && (is_cr || is_cc)) begin
      capture_cause_flag <= 1'b0;
    end
  end

  // Timer output rests at the polarity level while disabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_out <= 1'b0;
    end else if (!enable) begin
      timer_out <= input_polarity;
    end else if (out_enable && (cmp_evt || (is_gated && reload_evt))) begin
      timer_out <= !timer_out;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence seq_arm_edge;
    is_cc && arm == timer_cc_pkg::ARM_WAIT && qual_edge;
  endsequence
  sequence seq_armed_quiet;
    !timer_irq && arm == timer_cc_pkg::ARM_RUN;
  endsequence
  sequence seq_capture;
    cap_evt && !sw_count_wr;
  endsequence

  AST_COUNT_ON_TICK: assert property (
    ($past(count) != count) && !$past(sw_count_wr) && !$past(cap_evt) && !$past(reload_evt) |-> $past(tick))
    else $error("count moved without a prescale tick");
  AST_CAPTURE_COPY: assert property (
    seq_capture |=> capture == $past(count) && count == timer_cc_pkg::COUNT_RESTART)
    else $error("capture did not copy count and restart");
  AST_CAPTURE_EDGE: assert property (
    is_cr && rise && !input_polarity |-> cap_evt)
    else $error("rising edge missed with polarity zero");
  AST_CAPTURE_FLAG_IRQ: assert property (
    cap_evt && interrupt_source_select != timer_cc_pkg::ISEL_RELOAD_ONLY |=> timer_irq && capture_cause_flag)
    else $error("capture gave no interrupt or flag");
  AST_RELOAD_RESTART: assert property (
    reload_evt && is_cr && !sw_count_wr |=> count == timer_cc_pkg::COUNT_RESTART && !capture_cause_flag)
    else $error("reload did not restart count or clear flag");
  AST_COMPARE_CONTINUE: assert property (
    cmp_evt && !sw_count_wr |=> count == $past(count) + 16'h0001)
    else $error("compare match reset the count");
  AST_COMPARE_TOGGLE: assert property (
    cmp_evt && out_enable |=> timer_out != $past(timer_out))
    else $error("timer output did not toggle on compare");
  AST_COMPARE_WRAP: assert property (
    count_step && is_cmp && count == timer_cc_pkg::COUNT_MAX && reload != count && !sw_count_wr
    |=> count == timer_cc_pkg::COUNT_ZERO)
    else $error("count did not wrap to zero");
  AST_GATE_HOLD: assert property (
    is_gated && !in_active && !sw_count_wr |=> $stable(count))
    else $error("gated count moved while input inactive");
  AST_DEASSERT_IRQ: assert property (
    deassert_evt && interrupt_source_select != timer_cc_pkg::ISEL_RELOAD_ONLY |=> timer_irq)
    else $error("no interrupt on input deassertion");
  AST_GATED_RELOAD: assert property (
    is_gated && reload_evt && !sw_count_wr && interrupt_source_select != timer_cc_pkg::ISEL_INPUT_ONLY
    |=> count == timer_cc_pkg::COUNT_RESTART && timer_irq)
    else $error("gated reload did not restart at one");
  AST_GATED_TOGGLE: assert property (
    is_gated && reload_evt && out_enable |=> timer_out != $past(timer_out))
    else $error("gated reload did not toggle output");
  AST_FIRST_EDGE_QUIET: assert property (
    seq_arm_edge ##0 !input_evt ##0 !rc_evt |=> seq_armed_quiet)
    else $error("first edge raised interrupt or did not arm");
  AST_ISEL_INPUT_ONLY: assert property (
    interrupt_source_select == timer_cc_pkg::ISEL_INPUT_ONLY && rc_evt && !input_evt |=> !timer_irq)
    else $error("reload interrupt passed input-only filter");
  AST_RELOAD_ATOMIC: assert property (
    wr_en && idx == timer_cc_pkg::IDX_RELOAD_HIGH |=> $stable(reload))
    else $error("reload changed on a high-byte write");
  AST_CAPTURE_BEATS_RELOAD: assert property (
    cap_evt && match && !sw_count_wr |=> capture_cause_flag && count == timer_cc_pkg::COUNT_RESTART)
    else $error("reload won over a coincident capture");
  AST_CC_COMPARE_RESTART: assert property (
    reload_evt && is_cc && !sw_count_wr |=> count == timer_cc_pkg::COUNT_RESTART && !capture_cause_flag)
    else $error("capture/compare match did not restart or clear flag");
  AST_ISEL_RELOAD_ONLY: assert property (
    interrupt_source_select == timer_cc_pkg::ISEL_RELOAD_ONLY && input_evt && !rc_evt |=> !timer_irq)
    else $error("input interrupt passed reload-only filter");
  AST_DEFAULT_ALL_EVENTS: assert property (
    rc_evt && !interrupt_source_select[1] |=> timer_irq)
    else $error("reload or compare gave no interrupt by default");
endmodule // timer_capture_compare
`default_nettype wire

/* File: logic/timer_cc_pkg.sv */
// Shared constants for the capture/compare timer: register indices, fields, reset values, modes.
// Assumes an APB slave with one aligned 32-bit word per register (byte address = index * 4).
`default_nettype none
package timer_cc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_COUNT_HIGH = 4'h0;
  localparam logic [3:0] IDX_COUNT_LOW = 4'h1;
  localparam logic [3:0] IDX_RELOAD_HIGH = 4'h2;
  localparam logic [3:0] IDX_RELOAD_LOW = 4'h3;
  localparam logic [3:0] IDX_CAPTURE_HIGH = 4'h4;
  localparam logic [3:0] IDX_CAPTURE_LOW = 4'h5;
  localparam logic [3:0] IDX_CONTROL_REG_ZERO = 4'h6;
  localparam logic [3:0] IDX_CONTROL_REG_ONE = 4'h7;
  localparam logic [3:0] IDX_OUTPUT_CONTROL = 4'h8;
  localparam logic [3:0] IDX_LAST = 4'h8;
  localparam int ADDR_W = 8;
  // Reset and restart values
  localparam logic [15:0] COUNT_RESET = 16'h0001;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  // control_reg_zero fields
  localparam int CTL0_MODE_TOP_BIT = 7;
  localparam int CTL0_ISEL_LSB = 5;
  localparam int CTL0_DEADBAND_LSB = 1;
  localparam int CTL0_FLAG_BIT = 0;
  // control_reg_one fields
  localparam int CTL1_ENABLE_BIT = 7;
  localparam int CTL1_POLARITY_BIT = 6;
  localparam int CTL1_PRESCALE_LSB = 3;
  localparam int CTL1_MODE_LSB = 0;
  // output_control field
  localparam int OUT_ENABLE_BIT = 0;
  // Prescale counter width: factor up to 2**7
  localparam int PRESCALE_CNT_W = 7;
  // Interrupt source select codes
  localparam logic [1:0] ISEL_INPUT_ONLY = 2'h2;
  localparam logic [1:0] ISEL_RELOAD_ONLY = 2'h3;
  // Full mode value {mode_select_top, mode_select_low}
  typedef enum logic [3:0] {
    MODE_COMPARE = 4'h2,
    MODE_GATED = 4'h6,
    MODE_CAPTURE_COMPARE = 4'h7,
    MODE_CAPTURE_RESTART = 4'h8
  } mode_type;
  typedef enum logic [0:0] {
    ARM_WAIT = 1'b0,
    ARM_RUN = 1'b1
  } arm_type;
endpackage
`default_nettype wire

/* File: dv/timer_in_drv.sv */
// Far-side model: the outside circuit that drives the timer input pin.
// Assumes calls come right after a rising edge of clk_sys; the pin is a plain level.
`timescale 1ns/100ps
`default_nettype none
module timer_in_drv (
  output logic timer_in
);
  initial timer_in = 1'h0;
  // Non-blocking so the new level is first sampled at the next edge
  task automatic drive(input logic lvl);
    timer_in <= lvl;
  endtask
endmodule // timer_in_drv
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the capture/compare timer: APB master, pin driver, register model.
// Assumes zero or more APB wait states and a one-cycle interrupt pulse.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [3:0] CH = timer_cc_pkg::IDX_COUNT_HIGH;
  localparam logic [3:0] CL = timer_cc_pkg::IDX_COUNT_LOW;
  localparam logic [3:0] RH = timer_cc_pkg::IDX_RELOAD_HIGH;
  localparam logic [3:0] RL = timer_cc_pkg::IDX_RELOAD_LOW;
  localparam logic [3:0] PH = timer_cc_pkg::IDX_CAPTURE_HIGH;
  localparam logic [3:0] PL = timer_cc_pkg::IDX_CAPTURE_LOW;
  localparam logic [3:0] C0 = timer_cc_pkg::IDX_CONTROL_REG_ZERO;
  localparam logic [3:0] C1 = timer_cc_pkg::IDX_CONTROL_REG_ONE;
  localparam logic [3:0] OC = timer_cc_pkg::IDX_OUTPUT_CONTROL;
  logic clk_sys;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic errv;
  logic tog;
  logic timer_in;
  logic timer_out;
  logic timer_out_en;
  logic timer_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdv;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 32'h407F491E;
  int n, k, hold;
  int m [0:8];

  timer_capture_compare dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .timer_in(timer_in),
    .timer_out(timer_out),
    .timer_out_en(timer_out_en),
    .timer_irq(timer_irq)
  );
  timer_in_drv u_pin (.timer_in(timer_in));

  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic fail(input string nm);
    num_errors++;
    $display("[ERR] %s expected answer seen timeout", nm);
    stop_test();
  endtask
  // Ignored upper data bits carry random noise
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [31:0] r,
                     output logic e);
    int j;
    j = $random(seed);
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {j[31:8], v};
    @(posedge clk_sys);
    penable <= 1'h1;
    j = 0;
    do begin
      @(posedge clk_sys);
      j++;
    end while (pready !== 1'h1 && j < 20);
    if (j >= 20) fail("pready");
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Register model: reload high waits in a holding byte
  task automatic wr(input logic [3:0] i, input logic [7:0] v);
    apb(1'h1, {2'h0, i, 2'h0}, v, rdv, errv);
    if (i == RH) hold = v;
    else if (i == RL) begin
      m[RH] = hold;
      m[RL] = v;
    end else m[i] = (i == C0) ? (v & 8'hEE) : v;
  endtask
  task automatic rc(input string nm, input logic [3:0] i, input logic [31:0] e);
    apb(1'h0, {2'h0, i, 2'h0}, 8'h00, rdv, errv);
    check(nm, rdv, e);
  endtask
  task automatic watch(input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (timer_irq !== 1'h1 && c < lim);
  endtask
  task automatic wait_irq(output int c);
    watch(2000, c);
    if (timer_irq !== 1'h1) fail("irq");
  endtask
  task automatic quiet(input int lim);
    int c;
    watch(lim, c);
    check("no irq", timer_irq, 1'h0);
  endtask

  initial begin
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    m = '{0, 1, 255, 255, 0, 0, 0, 0, 0};
    hold = 255;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'h1;
    for (int i = 0; i < 9; i++) rc("reset value", 4'(i), m[i]);
    apb(1'h0, 8'h24, 8'h00, rdv, errv);
    check("unmapped err", errv, 1'h1);
    check("unmapped data", rdv, 32'h0);
    apb(1'h1, 8'h19, 8'hFF, rdv, errv);
    check("misaligned err", errv, 1'h1);
    rc("ctl0 after misaligned", C0, m[C0]);
    wr(C0, 8'hFF);
    rc("ctl0 fixed bits", C0, m[C0]);
    $display("test registers done");
    wr(C0, 8'h80);
    wr(RH, 8'h00);
    wr(RL, 8'h40);
    wr(RH, 8'h01);
    rc("reload held", RH, m[RH]);
    wr(RL, 8'h08);
    rc("reload joined", RH, m[RH]);
    wr(PH, 8'h00);
    wr(PL, 8'h00);
    wr(C1, 8'h88);
    wait_irq(n);
    wait_irq(n);
    check("reload period prescaled", n, 264 * 2);
    rc("flag after reload", C0, 8'h80);
    rc("capture untouched", PL, 8'h00);
    wr(C1, 8'h00);
    wr(CL, 8'h01);
    wr(RH, 8'h00);
    wr(RL, 8'h40);
    wr(C1, 8'h80);
    wait_irq(n);
    k = 4 + {$random(seed)} % 16;
    repeat (k) @(posedge clk_sys);
    u_pin.drive(1'h1);
    wait_irq(n);
    check("capture irq", n, 1);
    wait_irq(n);
    check("restart after capture", n, 64);
    rc("captured count", PL, k + 1);
    rc("flag after reload", C0, 8'h80);
    $display("test capture restart rising done");
    wr(C1, 8'hC0);
    wait_irq(n);
    repeat (k) @(posedge clk_sys);
    u_pin.drive(1'h0);
    wait_irq(n);
    check("falling capture irq", n, 1);
    rc("flag after capture", C0, 8'h81);
    rc("falling capture low", PL, k + 1);
    rc("falling capture high", PH, 8'h00);
    $display("test capture restart falling done");
    wr(C0, 8'hE0);
    wait_irq(n);
    repeat (5) @(posedge clk_sys);
    u_pin.drive(1'h1);
    repeat (5) @(posedge clk_sys);
    u_pin.drive(1'h0);
    wait_irq(n);
    check("capture masked, restart kept", n, 1 + 64);
    rc("masked capture value", PL, 11);
    wr(C0, 8'hC0);
    u_pin.drive(1'h1);
    repeat (3) @(posedge clk_sys);
    u_pin.drive(1'h0);
    wait_irq(n);
    check("input only capture", n, 1);
    quiet(150);
    $display("test interrupt select done");
    wr(C1, 8'h00);
    wr(C0, 8'h00);
    wr(OC, 8'h01);
    #1;
    check("output enable", timer_out_en, 1'h1);
    tog = timer_out;
    wr(CH, 8'hFF);
    wr(CL, 8'hF0);
    wr(RL, 8'h05);
    wr(C1, 8'h82);
    wait_irq(n);
    check("wrap then match", n, 22);
    check("compare toggle", timer_out, !tog);
    apb(1'h0, {2'h0, CL, 2'h0}, 8'h00, rdv, errv);
    check("no restart on compare", rdv, 7);
    $display("test compare done");
    wr(C1, 8'h00);
    wr(CH, 8'h00);
    wr(CL, 8'h08);
    wr(RL, 8'h10);
    wr(C1, 8'h86);
    quiet(20);
    rc("gated idle count", CL, 8'h08);
    u_pin.drive(1'h1);
    wait_irq(n);
    check("first pass from start", n, 9);
    tog = timer_out;
    wait_irq(n);
    check("later pass from one", n, 16);
    check("gated toggle", timer_out, !tog);
    repeat (5) @(posedge clk_sys);
    u_pin.drive(1'h0);
    wait_irq(n);
    check("deassert irq", n, 1);
    quiet(40);
    apb(1'h0, {2'h0, CL, 2'h0}, 8'h00, rdv, errv);
    check("gated count holds", rdv, 6);
    $display("test gated done");
    wr(C1, 8'h00);
    wr(CL, 8'h01);
    wr(C1, 8'h87);
    quiet(30);
    rc("held before edge", CL, 8'h01);
    u_pin.drive(1'h1);
    quiet(10);
    wait_irq(n);
    repeat (2) @(posedge clk_sys);
    u_pin.drive(1'h0);
    repeat (4) @(posedge clk_sys);
    u_pin.drive(1'h1);
    wait_irq(n);
    check("second edge capture", n, 1);
    rc("cc flag set", C0, 8'h01);
    rc("cc capture", PL, 7);
    wait_irq(n);
    wait_irq(n);
    check("cc compare restart", n, 16);
    rc("cc flag cleared", C0, 8'h00);
    $display("test capture compare done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
